// ### hstt_tuning_reg.v
`timescale 1ns/10ps
`include "hstt_consts.vh"

module hstt_tuning_reg
(
  input wire clk_i,
  input wire rst_n_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_en_i,
  input wire [7:0] reg_wr_data_i,
  input wire reg_rd_en_i,
  output reg [7:0] reg_rd_data_o,
  output reg reg_rd_valid_o,
  output reg reg_addr_err_o,
  input wire [7:0] otp_data_i,
  input wire [2:0] otp_field_valid_i,
  input wire chirp_active_i,
  output reg [1:0] hs_termination_trim_o,
  output reg [1:0] hs_transmit_slew_trim_o,
  output reg [3:0] hs_transmit_swing_trim_o,
  output reg swing_trim_bypass_o,
  output reg otp_loaded_o
);

  // ----------------------------------------------------------------
  // Load sequencer states
  // ----------------------------------------------------------------
  localparam ST_RESET = 2'b00;
  localparam ST_OTP_LOAD = 2'b01;
  localparam ST_RUN = 2'b10;

  // ----------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------
  function hit_tuning;
    input [7:0] addr;
    begin
      hit_tuning = (addr == `HSTT_TUNING_OFFSET);
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] hs_transmit_tuning_port0_reg;
  reg [7:0] hs_transmit_tuning_port0_next;
  reg [7:0] rd_data_next;
  reg rd_valid_next;
  reg addr_err_next;
  reg [3:0] swing_next;
  reg bypass_next;
  wire [7:0] otp_merged;
  wire wr_hit;
  wire rd_hit;

  assign wr_hit = reg_wr_en_i & hit_tuning(reg_addr_i);
  assign rd_hit = reg_rd_en_i & hit_tuning(reg_addr_i);

  // ----------------------------------------------------------------
  // OTP default merge
  // ----------------------------------------------------------------
  hstt_otp_merge u_otp_merge
  (
    .hw_default_i(`HSTT_TUNING_RESET),
    .otp_data_i(otp_data_i),
    .otp_field_valid_i(otp_field_valid_i),
    .merged_o(otp_merged)
  );

  // ----------------------------------------------------------------
  // Load sequencer
  // ----------------------------------------------------------------
  always @*
  begin
    // OTP image taken once, two edges after reset
    case (state_reg)
      ST_RESET:
        state_next = ST_OTP_LOAD;
      ST_OTP_LOAD:
        state_next = ST_RUN;
      ST_RUN:
        state_next = ST_RUN;
      default:
        state_next = ST_RESET;
    endcase
  end

  // ----------------------------------------------------------------
  // Register next value
  // ----------------------------------------------------------------
  always @*
  begin
    hs_transmit_tuning_port0_next = hs_transmit_tuning_port0_reg;
    // Writes before RUN dropped so the OTP image lands intact
    case (state_reg)
      ST_OTP_LOAD:
        hs_transmit_tuning_port0_next = otp_merged;
      ST_RUN:
        if (wr_hit)
        begin
          hs_transmit_tuning_port0_next = reg_wr_data_i;
        end
      ST_RESET:
        hs_transmit_tuning_port0_next = `HSTT_TUNING_RESET;
      default:
        hs_transmit_tuning_port0_next = `HSTT_TUNING_RESET;
    endcase
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always @*
  begin
    // Reads see the stored field, not the chirp override
    rd_data_next = `HSTT_UNMAPPED_DATA;
    rd_valid_next = 1'b0;
    addr_err_next = 1'b0;
    if (reg_rd_en_i)
    begin
      rd_valid_next = 1'b1;
      if (rd_hit)
      begin
        rd_data_next = hs_transmit_tuning_port0_reg;
      end
      else
      begin
        addr_err_next = 1'b1;
      end
    end
    else if (reg_wr_en_i && !wr_hit)
    begin
      addr_err_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Swing trim as seen by the transmitter
  // ----------------------------------------------------------------
  always @*
  begin
    // Stored field untouched while chirp forces nominal
    if (chirp_active_i)
    begin
      swing_next = `HSTT_SWING_NOMINAL;
      bypass_next = 1'b1;
    end
    else
    begin
      swing_next = hs_transmit_tuning_port0_next[`HSTT_SWING_MSB:
                                                 `HSTT_SWING_LSB];
      bypass_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State and register flops
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= ST_RESET;
      hs_transmit_tuning_port0_reg <= `HSTT_TUNING_RESET;
      otp_loaded_o <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      hs_transmit_tuning_port0_reg <= hs_transmit_tuning_port0_next;
      otp_loaded_o <= (state_next == ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // Bus answer flops
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      reg_rd_data_o <= `HSTT_UNMAPPED_DATA;
      reg_rd_valid_o <= 1'b0;
      reg_addr_err_o <= 1'b0;
    end
    else
    begin
      // Answer one edge after the strobe
      reg_rd_data_o <= rd_data_next;
      reg_rd_valid_o <= rd_valid_next;
      reg_addr_err_o <= addr_err_next;
    end
  end

  // ----------------------------------------------------------------
  // Trim outputs to the analog transmitter
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      hs_termination_trim_o <= `HSTT_TERM_RESET;
      hs_transmit_slew_trim_o <= `HSTT_SLEW_RESET;
      hs_transmit_swing_trim_o <= `HSTT_SWING_RESET;
      swing_trim_bypass_o <= 1'b0;
    end
    else
    begin
      // Follow next value so a write shows after one edge
      hs_termination_trim_o <=
        hs_transmit_tuning_port0_next[`HSTT_TERM_MSB:
                                      `HSTT_TERM_LSB];
      hs_transmit_slew_trim_o <=
        hs_transmit_tuning_port0_next[`HSTT_SLEW_MSB:
                                      `HSTT_SLEW_LSB];
      hs_transmit_swing_trim_o <= swing_next;
      swing_trim_bypass_o <= bypass_next;
    end
  end

endmodule

// ### hstt_consts.vh
`ifndef HSTT_CONSTS_VH
`define HSTT_CONSTS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define HSTT_ADDR_W 8
`define HSTT_DATA_W 8
`define HSTT_TUNING_OFFSET 8'h30
`define HSTT_TUNING_RESET 8'h77
`define HSTT_UNMAPPED_DATA 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HSTT_TERM_MSB 7
`define HSTT_TERM_LSB 6
`define HSTT_SLEW_MSB 5
`define HSTT_SLEW_LSB 4
`define HSTT_SWING_MSB 3
`define HSTT_SWING_LSB 0

// ----------------------------------------------------------------
// Field resets and codes
// ----------------------------------------------------------------
`define HSTT_TERM_RESET 2'h1
`define HSTT_SLEW_RESET 2'h3
`define HSTT_SWING_RESET 4'h7
`define HSTT_SWING_NOMINAL 4'h3

// ----------------------------------------------------------------
// OTP field-valid mask bit order
// ----------------------------------------------------------------
`define HSTT_OTP_FIELDS 3
`define HSTT_OTP_TERM_BIT 2
`define HSTT_OTP_SLEW_BIT 1
`define HSTT_OTP_SWING_BIT 0

`endif

// ### hstt_otp_merge.v
`timescale 1ns/10ps
`include "hstt_consts.vh"

module hstt_otp_merge
(
  input wire [7:0] hw_default_i,
  input wire [7:0] otp_data_i,
  input wire [2:0] otp_field_valid_i,
  output wire [7:0] merged_o
);

  // ----------------------------------------------------------------
  // Per-field selection of OTP over hardware default
  // ----------------------------------------------------------------
  assign merged_o[`HSTT_TERM_MSB:`HSTT_TERM_LSB] =
    otp_field_valid_i[`HSTT_OTP_TERM_BIT] ?
    otp_data_i[`HSTT_TERM_MSB:`HSTT_TERM_LSB] :
    hw_default_i[`HSTT_TERM_MSB:`HSTT_TERM_LSB];

  assign merged_o[`HSTT_SLEW_MSB:`HSTT_SLEW_LSB] =
    otp_field_valid_i[`HSTT_OTP_SLEW_BIT] ?
    otp_data_i[`HSTT_SLEW_MSB:`HSTT_SLEW_LSB] :
    hw_default_i[`HSTT_SLEW_MSB:`HSTT_SLEW_LSB];

  assign merged_o[`HSTT_SWING_MSB:`HSTT_SWING_LSB] =
    otp_field_valid_i[`HSTT_OTP_SWING_BIT] ?
    otp_data_i[`HSTT_SWING_MSB:`HSTT_SWING_LSB] :
    hw_default_i[`HSTT_SWING_MSB:`HSTT_SWING_LSB];

endmodule

// ### hstt_tuning_reg_monitor.sv
`timescale 1ns/10ps
module hstt_tuning_reg_monitor
(
  input wire clk_i,
  input wire rst_n_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_en_i,
  input wire [7:0] reg_wr_data_i,
  input wire reg_rd_en_i,
  input wire [7:0] reg_rd_data_o,
  input wire reg_rd_valid_o,
  input wire reg_addr_err_o,
  input wire chirp_active_i,
  input wire otp_loaded_o,
  input wire [1:0] hs_termination_trim_o,
  input wire [1:0] hs_transmit_slew_trim_o,
  input wire [3:0] hs_transmit_swing_trim_o,
  input wire swing_trim_bypass_o
);
  // ----
  // Port checks
  // ----
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire hit = (reg_addr_i == 8'h30);
  wire wok = reg_wr_en_i && hit && otp_loaded_o;
  a_read_answer: assert property
    (reg_rd_en_i && hit |=> reg_rd_valid_o)
    else $error("read not answered");
  a_idle_read_zero: assert property (!reg_rd_en_i |=> !reg_rd_data_o)
    else $error("read data not zero");
  a_unmapped_err: assert property
    ((reg_rd_en_i || reg_wr_en_i) && !hit |=> reg_addr_err_o)
    else $error("unmapped access not flagged");
  a_write_term: assert property (wok
    |=> hs_termination_trim_o == $past(reg_wr_data_i[7:6]))
    else $error("termination field wrong");
  a_write_slew: assert property (wok
    |=> hs_transmit_slew_trim_o == $past(reg_wr_data_i[5:4]))
    else $error("slew field wrong");
  a_write_swing: assert property (wok && !chirp_active_i
    |=> hs_transmit_swing_trim_o == $past(reg_wr_data_i[3:0]))
    else $error("swing field wrong");
  a_chirp_forced: assert property (chirp_active_i
    |=> hs_transmit_swing_trim_o == 4'h3 && swing_trim_bypass_o)
    else $error("swing not forced in chirp");
  a_chirp_release: assert property
    (!chirp_active_i |=> !swing_trim_bypass_o)
    else $error("bypass left high");
  c_write: cover property (wok);
  c_chirp: cover property (chirp_active_i ##1 !chirp_active_i);
  c_unmapped: cover property (reg_rd_en_i && !hit);
endmodule

bind hstt_tuning_reg hstt_tuning_reg_monitor i_mon(.*);

// ### hstt_tuning_reg_bench.sv
`timescale 1ns/10ps
module hstt_tuning_reg_bench;
  reg clk_i = 0, rst_n_i = 0, wr = 0, rd = 0, chirp = 0;
  reg [7:0] addr = 8'h30, wdat = 8'h00, otp = 8'h00;
  reg [2:0] ov = 3'h0;
  reg [31:0] lf = 32'hae22;
  wire [7:0] rdat;
  wire [1:0] term, slew;
  wire [3:0] sw;
  wire rv, err, byp, ld;
  integer n_mismatch = 0, checked = 0, mdl, i, j;
  hstt_tuning_reg i_hstt_tuning_reg(.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(addr), .reg_wr_en_i(wr), .reg_wr_data_i(wdat),
    .reg_rd_en_i(rd), .reg_rd_data_o(rdat), .reg_rd_valid_o(rv),
    .reg_addr_err_o(err), .otp_data_i(otp), .otp_field_valid_i(ov),
    .chirp_active_i(chirp), .hs_termination_trim_o(term),
    .hs_transmit_slew_trim_o(slew), .hs_transmit_swing_trim_o(sw),
    .swing_trim_bypass_o(byp), .otp_loaded_o(ld));
  initial forever #12.5 clk_i = ~clk_i;
  // ----
  // Helpers
  // ----
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task outs;
  begin
    chk("term", term, mdl[7:6]);
    chk("slew", slew, mdl[5:4]);
    chk("swing", sw, chirp ? 4'h3 : mdl[3:0]);
    chk("bypass", byp, chirp);
  end
  endtask
  task wr_t(input [7:0] a, input [7:0] d);
  begin
    @(negedge clk_i) addr = a;
    wdat = d;
    wr = 1;
    @(negedge clk_i) wr = 0;
    if (a == 8'h30) mdl = d;
    chk("wr_err", err, a != 8'h30);
  end
  endtask
  task rd_t(input [7:0] a);
  begin
    @(negedge clk_i) addr = a;
    rd = 1;
    @(negedge clk_i) rd = 0;
    chk("valid", rv, 1);
    chk("rdata", rdat, a == 8'h30 ? mdl[7:0] : 8'h00);
    chk("rd_err", err, a != 8'h30);
  end
  endtask
  task rst_t(input [2:0] v);
  begin
    @(negedge clk_i) rst_n_i = 0;
    otp = lf[7:0];
    ov = v;
    lf = nxt(lf);
    mdl = {v[2] ? otp[7:6] : 2'h1, v[1] ? otp[5:4] : 2'h3,
      v[0] ? otp[3:0] : 4'h7};
    repeat (6) @(negedge clk_i);
    rst_n_i = 1;
    // Writes during the OTP load must be dropped
    addr = 8'h30;
    wdat = ~mdl[7:0];
    wr = 1;
    i = 0;
    while (ld !== 1'b1 && i < 8)
    begin
      @(negedge clk_i);
      i = i + 1;
      if (i == 2) wr = 0;
    end
    if (i < 2) wr = 0;
    chk("load_cyc", i[7:0], 8'h02);
    if (i == 8) give_verdict;
    outs;
  end
  endtask
  task give_verdict;
  begin
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  // ----
  // Main sequence
  // ----
  initial
  begin
    for (j = 0; j < 8; j = j + 1)
    begin
      rst_t(j);
      rd_t(8'h30);
    end
    for (j = 0; j < 24; j = j + 1)
    begin
      wr_t(8'h30, lf[7:0]);
      lf = nxt(lf);
      outs;
      rd_t(8'h30);
    end
    wr_t(8'h31, 8'h5a);
    rd_t(8'h31);
    wr_t(8'h2f, 8'ha5);
    rd_t(8'hff);
    outs;
    @(negedge clk_i) chirp = 1;
    @(negedge clk_i) outs;
    wr_t(8'h30, 8'hcf);
    outs;
    rd_t(8'h30);
    @(negedge clk_i) chirp = 0;
    @(negedge clk_i) outs;
    give_verdict;
  end
endmodule
